//--- pcr_pkg.sv
// Function
// - Vendor_identifier 16 bits at 0x000, never ffff
// - Device_identifier 16 bits beside vendor_identifier
// - Revision_identifier 8 bits at 0x008
// - Class code 24 bits beside revision
// - Subsystem_vendor_identifier at 0x02c, never ffff
// - Subsystem ids exist only for type 0 endpoints
// - Ids reloadable at run time, read-only to config
// - Timeout ranges field, one bit per range
// - Ranges encoding limited to listed values
// - Zero ranges means fixed timeout up to 50 ms
// - Ranges field zero unless root or requester endpoint
// - Device control 2 selects and enables timeout
// - Timeout never expires below 10 ms
package pcr_pkg;
  localparam logic [11:0] PCR_OFS_ID = 12'h000;
  localparam logic [11:0] PCR_OFS_CLASS = 12'h008;
  localparam logic [11:0] PCR_OFS_SUBSYS = 12'h02c;
  localparam logic [11:0] PCR_OFS_DEVCAP = 12'h084;
  localparam logic [11:0] PCR_OFS_DEVCTL2 = 12'h0a8;
  localparam logic [15:0] PCR_ID_INVALID = 16'hffff;
  localparam logic [2:0] PCR_MPS_128 = 3'h0;
  localparam logic [2:0] PCR_MPS_256 = 3'h1;
  localparam logic [3:0] PCR_CTO_DEFAULT = 4'hf;
  localparam logic [3:0] PCR_CTO_CTL_RESET = 4'h0;
  localparam int PCR_CLK_HZ = 20000000;
  localparam int PCR_FIXED_TO_MS = 50;
  localparam int PCR_MIN_TO_MS = 10;
  localparam int PCR_FIXED_TO_CYC = PCR_FIXED_TO_MS * (PCR_CLK_HZ / 1000);
  localparam int PCR_MIN_TO_CYC = PCR_MIN_TO_MS * (PCR_CLK_HZ / 1000);
  typedef struct packed {
    logic [15:0] vendor_identifier;
    logic [15:0] device_identifier;
    logic [7:0] revision_identifier;
    logic [23:0] function_class_code;
    logic [15:0] subsystem_vendor_identifier;
    logic [15:0] subsystem_device_identifier;
  } pcr_ids_t;
  typedef struct packed {
    logic req;
    logic wr;
    logic [11:0] addr;
    logic [31:0] wdata;
  } pcr_cfg_req_t;
  // Timeout ranges field: legal 4-bit range codes
  function automatic logic pcr_cto_legal(input logic [3:0] v);
    case (v)
      4'h0, 4'h1, 4'h2, 4'h3, 4'h6, 4'h7, 4'he, 4'hf: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : pcr_cto_legal
endpackage : pcr_pkg

//--- pcr_cto_timer.sv
`timescale 1ns/10ps
module pcr_cto_timer
  import pcr_pkg::*;
#(
  parameter int LIMIT_W = 32
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic start_i,
  input wire logic stop_i,
  input wire logic [LIMIT_W-1:0] limit_i,
  output logic busy_o,
  output logic expired_o
);
  logic [LIMIT_W-1:0] count;
  initial begin
    if (LIMIT_W < 1) $error("Limit width must be positive");
  end
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      count <= '0;
      busy_o <= 1'b0;
      expired_o <= 1'b0;
    end else if (ce_i) begin
      expired_o <= 1'b0;
      if (stop_i) begin
        busy_o <= 1'b0;
      end else if (start_i) begin
        busy_o <= 1'b1;
        count <= '0;
      end else if (busy_o) begin
        if (count + 1'b1 >= limit_i) begin
          busy_o <= 1'b0;
          expired_o <= 1'b1;
        end else begin
          count <= count + 1'b1;
        end
      end
    end
  end
endmodule : pcr_cto_timer

//--- pcr_cfg_regs.sv
`timescale 1ns/10ps
module pcr_cfg_regs
  import pcr_pkg::*;
#(
  parameter logic [15:0] VENDOR_IDENTIFIER = 16'h1234,   // Arbitrary value
  parameter logic [15:0] DEVICE_IDENTIFIER = 16'h5678,   // Arbitrary value
  parameter logic [7:0] REVISION_IDENTIFIER = 8'h0a,     // Arbitrary value
  parameter logic [23:0] CLASS_CODE = 24'h0b4000,
  parameter logic [15:0] SUBSYS_VENDOR_IDENTIFIER = 16'h1234, // Arbitrary value
  parameter logic [15:0] SUBSYS_DEVICE_IDENTIFIER = 16'h9abc, // Arbitrary value
  parameter bit TYPE0_ENDPOINT = 1'b1,
  parameter bit REQUESTER = 1'b1,
  parameter int MAX_PAYLOAD = 128,
  parameter logic [3:0] CTO_RANGES = PCR_CTO_DEFAULT,
  parameter int FIXED_TO_CYC = PCR_FIXED_TO_CYC,
  parameter int MIN_TO_CYC = PCR_MIN_TO_CYC
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire pcr_cfg_req_t cfg_req_i,
  output logic cfg_ack_o,
  output logic [31:0] cfg_rdata_o,
  input wire logic reconf_we_i,
  input wire pcr_ids_t reconf_ids_i,
  input wire logic cpl_start_i,
  input wire logic cpl_done_i,
  output logic cpl_timeout_o,
  output logic cpl_pending_o
);
  initial begin
    if (VENDOR_IDENTIFIER == PCR_ID_INVALID || SUBSYS_VENDOR_IDENTIFIER == PCR_ID_INVALID)
      $error("Vendor identifier may not be all ones");
    if (MAX_PAYLOAD != 128 && MAX_PAYLOAD != 256)
      $error("Max payload must be 128 or 256");
    if (!pcr_cto_legal(CTO_RANGES))
      $error("Reserved completion timeout range code");
    if (MIN_TO_CYC < 1 || FIXED_TO_CYC < MIN_TO_CYC)
      $error("Bad timeout cycle counts");
    // Range C needs 100 times the floor in a 32-bit limit
    if (MIN_TO_CYC > 42949672)
      $error("Range C count overflows 32 bits");
  end

  localparam logic [3:0] RANGES_EFF =
    (REQUESTER) ? CTO_RANGES : 4'h0;
  localparam logic [2:0] MPS_CODE =
    (MAX_PAYLOAD == 256) ? PCR_MPS_256 : PCR_MPS_128;
  localparam logic [31:0] MIN_CYC = 32'(MIN_TO_CYC);
  localparam logic [31:0] FIX_CYC = 32'(FIXED_TO_CYC);

  pcr_ids_t ids;
  logic [3:0] cto_value;
  logic cto_disable;
  logic [31:0] next_rdata;
  logic [31:0] limit;
  logic wr_any;

  // Ids only change through reconfiguration, never config writes
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ids <= '{VENDOR_IDENTIFIER, DEVICE_IDENTIFIER, REVISION_IDENTIFIER, CLASS_CODE,
               SUBSYS_VENDOR_IDENTIFIER, SUBSYS_DEVICE_IDENTIFIER};
    end else if (ce_i && reconf_we_i &&
                 reconf_ids_i.vendor_identifier != PCR_ID_INVALID &&
                 reconf_ids_i.subsystem_vendor_identifier
                   != PCR_ID_INVALID) begin
      ids <= reconf_ids_i;
    end
  end

  assign wr_any = cfg_req_i.req && cfg_req_i.wr;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      cto_value <= PCR_CTO_CTL_RESET;
      cto_disable <= 1'b0;
    end else if (ce_i && wr_any && cfg_req_i.addr == PCR_OFS_DEVCTL2) begin
      cto_value <= cfg_req_i.wdata[3:0];
      cto_disable <= cfg_req_i.wdata[4];
    end
  end

  always_comb begin
    next_rdata = 32'h0;
    case (cfg_req_i.addr)
      PCR_OFS_ID:
        next_rdata = {ids.device_identifier,
                      ids.vendor_identifier};
      PCR_OFS_CLASS:
        next_rdata = {ids.function_class_code,
                      ids.revision_identifier};
      PCR_OFS_SUBSYS:
        if (TYPE0_ENDPOINT) begin
          next_rdata = {ids.subsystem_device_identifier,
                        ids.subsystem_vendor_identifier};
        end
      PCR_OFS_DEVCAP:
        next_rdata = {29'h0, MPS_CODE};
      PCR_OFS_DEVCTL2:
        next_rdata = {27'h0, cto_disable, cto_value};
      default:
        next_rdata = 32'h0;
    endcase
  end

  // Writes are acknowledged like reads; RO targets ignore data
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      cfg_ack_o <= 1'b0;
      cfg_rdata_o <= 32'h0;
    end else if (ce_i) begin
      cfg_ack_o <= cfg_req_i.req;
      if (cfg_req_i.req && !cfg_req_i.wr) begin
        cfg_rdata_o <= next_rdata;
      end
    end
  end

  // Range picks a multiple of the floor; floor keeps 10 ms minimum
  always_comb begin
    limit = FIX_CYC;
    // Unsupported range falls back to the fixed timeout
    case (cto_value)
      4'h1, 4'h2: begin
        if (RANGES_EFF[0]) limit = MIN_CYC;
      end
      4'h5, 4'h6: begin
        if (RANGES_EFF[1]) limit = 32'(MIN_CYC * 25);
      end
      4'h9, 4'ha: begin
        if (RANGES_EFF[2]) limit = 32'(MIN_CYC * 100);
      end
      default: limit = FIX_CYC;
    endcase
    if (limit < MIN_CYC) limit = MIN_CYC;
  end

  pcr_cto_timer #(
    .LIMIT_W(32)
  ) u_timer (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .start_i(cpl_start_i && !cto_disable),
    .stop_i(cpl_done_i),
    .limit_i(limit),
    .busy_o(cpl_pending_o),
    .expired_o(cpl_timeout_o)
  );

  logic [31:0] wait_cnt;
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      wait_cnt <= 32'h0;
    end else if (ce_i) begin
      if (!cpl_pending_o) wait_cnt <= 32'h0;
      else wait_cnt <= wait_cnt + 32'h1;
    end
  end

  property p_ro_write;
    @(posedge core_clk_i) disable iff (rst_i)
    (ce_i && wr_any && !reconf_we_i) |=> $stable(ids);
  endproperty
  a_ro_write: assert property (p_ro_write)
    else $error("Id changed");
  property p_ack;
    @(posedge core_clk_i) disable iff (rst_i)
    (ce_i && cfg_req_i.req) |=> cfg_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("No ack");
  property p_vid;
    @(posedge core_clk_i) disable iff (rst_i)
    ids.vendor_identifier != PCR_ID_INVALID;
  endproperty
  a_vid: assert property (p_vid) else $error("Vendor_identifier ffff");
  property p_svid;
    @(posedge core_clk_i) disable iff (rst_i)
    ids.subsystem_vendor_identifier != PCR_ID_INVALID;
  endproperty
  a_svid: assert property (p_svid) else $error("Subsys id ffff");
  property p_id_read;
    @(posedge core_clk_i) disable iff (rst_i)
    (ce_i && cfg_req_i.req && !cfg_req_i.wr &&
     cfg_req_i.addr == PCR_OFS_ID) |=>
    cfg_rdata_o == {$past(ids.device_identifier),
                    $past(ids.vendor_identifier)};
  endproperty
  a_id_read: assert property (p_id_read) else $error("Id read");
  property p_class_read;
    @(posedge core_clk_i) disable iff (rst_i)
    (ce_i && cfg_req_i.req && !cfg_req_i.wr &&
     cfg_req_i.addr == PCR_OFS_CLASS) |=>
    cfg_rdata_o[7:0] == $past(ids.revision_identifier);
  endproperty
  a_class_read: assert property (p_class_read)
    else $error("Rev read");
  property p_mps;
    @(posedge core_clk_i) disable iff (rst_i)
    (ce_i && cfg_req_i.req && !cfg_req_i.wr &&
     cfg_req_i.addr == PCR_OFS_DEVCAP) |=> cfg_rdata_o[2:0] <= PCR_MPS_256;
  endproperty
  a_mps: assert property (p_mps) else $error("Bad payload code");
  property p_min_to;
    @(posedge core_clk_i) disable iff (rst_i)
    cpl_timeout_o |-> $past(wait_cnt) + 32'h1 >= MIN_CYC;
  endproperty
  a_min_to: assert property (p_min_to) else $error("Early timeout");
  property p_disable;
    @(posedge core_clk_i) disable iff (rst_i)
    (cto_disable && !cpl_pending_o) |=> !cpl_pending_o;
  endproperty
  a_disable: assert property (p_disable) else $error("Timer ran");
  property p_class_code;
    @(posedge core_clk_i) disable iff (rst_i)
    (ce_i && cfg_req_i.req && !cfg_req_i.wr &&
     cfg_req_i.addr == PCR_OFS_CLASS) |=>
    cfg_rdata_o[31:8] == $past(ids.function_class_code);
  endproperty
  a_class_code: assert property (p_class_code)
    else $error("Class read");
  property p_subsys_read;
    @(posedge core_clk_i) disable iff (rst_i)
    (ce_i && cfg_req_i.req && !cfg_req_i.wr &&
     cfg_req_i.addr == PCR_OFS_SUBSYS) |=>
    cfg_rdata_o == (TYPE0_ENDPOINT ?
                    {$past(ids.subsystem_device_identifier),
                     $past(ids.subsystem_vendor_identifier)} : 32'h0);
  endproperty
  a_subsys_read: assert property (p_subsys_read)
    else $error("Subsystem read");
  property p_ack_pulse;
    @(posedge core_clk_i) disable iff (rst_i)
    (ce_i && !cfg_req_i.req) |=> !cfg_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("Stray ack");
  c_read: cover property (@(posedge core_clk_i) cfg_ack_o && !rst_i);
  c_reconf: cover property (@(posedge core_clk_i) ce_i && reconf_we_i);
  c_timeout: cover property (@(posedge core_clk_i) cpl_timeout_o);
endmodule : pcr_cfg_regs

//--- pcr_rc_model.sv
`timescale 1ns/10ps
module pcr_rc_model
  import pcr_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic cfg_ack_i,
  input wire logic [31:0] cfg_rdata_i,
  output pcr_cfg_req_t cfg_req_o
);
  initial cfg_req_o = '0;
  // One request per pulse; ack must show by the falling edge after the taking edge
  task automatic xfer(input logic wr, input logic [11:0] addr,
                      input logic [31:0] wdata, output logic [31:0] rdata,
                      output logic ok);
    @(negedge core_clk_i);
    cfg_req_o = '{req: 1'b1, wr: wr, addr: addr, wdata: wdata};
    @(negedge core_clk_i);
    cfg_req_o.req = 1'b0;
    // Released fields stop showing the old value
    cfg_req_o.wdata = ~wdata;
    cfg_req_o.addr = ~addr;
    ok = (cfg_ack_i === 1'b1);
    rdata = cfg_rdata_i;
  endtask : xfer
endmodule : pcr_rc_model

//--- pcie_config_id_and_capability_regs_bench.sv
`timescale 1ns/10ps
module pcie_config_id_and_capability_regs_bench;
  import pcr_pkg::*;
  localparam int FIX_CYC = 20;
  localparam int MIN_CYC = 4;
  localparam pcr_ids_t IDS0 = '{16'h1b2c, 16'h3d4e, 8'h05, 24'h0b4000,
                                16'h2a3b, 16'h4c5d}; // Arbitrary values
  localparam pcr_ids_t IDS1 = '{16'h6e7f, 16'h8091, 8'h0c, 24'h058000,
                                16'h7788, 16'h99aa}; // Arbitrary values
  typedef struct {
    logic [11:0] a;
    logic [31:0] m;
    logic [31:0] e;
  } pcr_row_t;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic reconf_we = 1'b0;
  logic cpl_start = 1'b0;
  logic cpl_done = 1'b0;
  pcr_ids_t reconf_ids = IDS0;
  pcr_cfg_req_t cfg_req;
  logic cfg_ack;
  logic cpl_timeout;
  logic cpl_pending;
  logic [31:0] cfg_rdata;
  int error_cnt = 0;
  int compares = 0;
  pcr_row_t rows[6] = '{
    '{PCR_OFS_ID, 32'hffffffff, {IDS0.device_identifier,
                                 IDS0.vendor_identifier}},
    '{PCR_OFS_CLASS, 32'hffffffff, {IDS0.function_class_code,
                                    IDS0.revision_identifier}},
    '{PCR_OFS_SUBSYS, 32'hffffffff, {IDS0.subsystem_device_identifier,
                                     IDS0.subsystem_vendor_identifier}},
    '{PCR_OFS_DEVCAP, 32'h00000007, {29'h0, PCR_MPS_128}},
    '{PCR_OFS_DEVCTL2, 32'h0000001f, 32'h0},
    '{12'h100, 32'hffffffff, 32'h0}};

  always #25 core_clk = ~core_clk;

  pcr_cfg_regs #(
    .VENDOR_IDENTIFIER(IDS0.vendor_identifier),
    .DEVICE_IDENTIFIER(IDS0.device_identifier),
    .REVISION_IDENTIFIER(IDS0.revision_identifier),
    .CLASS_CODE(IDS0.function_class_code),
    .SUBSYS_VENDOR_IDENTIFIER(IDS0.subsystem_vendor_identifier),
    .SUBSYS_DEVICE_IDENTIFIER(IDS0.subsystem_device_identifier),
    .FIXED_TO_CYC(FIX_CYC),
    .MIN_TO_CYC(MIN_CYC)
  ) u_dut (
    .core_clk_i(core_clk), .rst_i(rst), .ce_i(ce), .cfg_req_i(cfg_req),
    .cfg_ack_o(cfg_ack), .cfg_rdata_o(cfg_rdata),
    .reconf_we_i(reconf_we), .reconf_ids_i(reconf_ids),
    .cpl_start_i(cpl_start), .cpl_done_i(cpl_done),
    .cpl_timeout_o(cpl_timeout), .cpl_pending_o(cpl_pending));

  pcr_rc_model u_rc (.core_clk_i(core_clk), .cfg_ack_i(cfg_ack),
                     .cfg_rdata_i(cfg_rdata), .cfg_req_o(cfg_req));

  task automatic check(input string what, input logic [31:0] exp, got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask : check

  task automatic acc(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd, output logic [31:0] d);
    logic ok;
    u_rc.xfer(wr, a, wd, d, ok);
    check("ack", 32'h1, {31'h0, ok});
  endtask : acc

  task automatic reload(input pcr_ids_t v);
    @(negedge core_clk);
    reconf_ids = v;
    reconf_we = 1'b1;
    @(negedge core_clk);
    reconf_we = 1'b0;
  endtask : reload

  // Pulses start, then counts cycles to expiry; bounded so a hang ends
  task automatic time_out(output int n);
    @(negedge core_clk);
    cpl_start = 1'b1;
    @(negedge core_clk);
    cpl_start = 1'b0;
    check("pending", 32'h1, {31'h0, cpl_pending});
    n = 0;
    while (cpl_timeout !== 1'b1 && n < 200) begin
      @(negedge core_clk);
      n++;
    end
  endtask : time_out

  task automatic summarize();
    if (error_cnt == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : summarize

  initial begin
    #(50 * 3000);
    error_cnt++;
    summarize();
  end

  initial begin
    logic [31:0] d;
    pcr_ids_t v;
    int n;
    logic ok;
    repeat (4) @(negedge core_clk);
    rst = 1'b0;
    check("rdata rst", 32'h0, cfg_rdata);
    check("pend rst", 32'h0, {31'h0, cpl_pending});
    foreach (rows[i]) begin
      acc(1'b0, rows[i].a, 32'h0, d);
      check("row", rows[i].e, d & rows[i].m);
    end
    acc(1'b1, PCR_OFS_ID, 32'h0, d);
    acc(1'b0, PCR_OFS_ID, 32'h0, d);
    check("ro id", rows[0].e, d);
    acc(1'b1, PCR_OFS_DEVCAP, 32'h1, d);
    acc(1'b0, PCR_OFS_DEVCAP, 32'h0, d);
    check("ro mps", {29'h0, PCR_MPS_128}, d & 32'h7);
    reload(IDS1);
    acc(1'b0, PCR_OFS_SUBSYS, 32'h0, d);
    check("reconf", {IDS1.subsystem_device_identifier,
                     IDS1.subsystem_vendor_identifier}, d);
    v = IDS0;
    v.vendor_identifier = PCR_ID_INVALID;
    reload(v);
    acc(1'b0, PCR_OFS_ID, 32'h0, d);
    check("bad vid", {IDS1.device_identifier,
                      IDS1.vendor_identifier}, d);
    // Short counts stand in for 50 ms and 10 ms
    time_out(n);
    check("fixed", FIX_CYC, n);
    acc(1'b1, PCR_OFS_DEVCTL2, 32'h5, d);
    time_out(n);
    check("range b", 25 * MIN_CYC, n);
    acc(1'b1, PCR_OFS_DEVCTL2, 32'h1, d);
    time_out(n);
    check("range a", MIN_CYC, n);
    @(negedge core_clk);
    cpl_start = 1'b1;
    @(negedge core_clk);
    cpl_start = 1'b0;
    cpl_done = 1'b1;
    @(negedge core_clk);
    cpl_done = 1'b0;
    n = 0;
    repeat (FIX_CYC + 4) begin
      @(negedge core_clk);
      n += (cpl_timeout === 1'b1);
    end
    check("done stop", 32'h0, n);
    acc(1'b1, PCR_OFS_DEVCTL2, 32'h10, d);
    @(negedge core_clk);
    cpl_start = 1'b1;
    @(negedge core_clk);
    cpl_start = 1'b0;
    @(negedge core_clk);
    check("disabled", 32'h0, {31'h0, cpl_pending});
    ce = 1'b0;
    u_rc.xfer(1'b1, PCR_OFS_DEVCTL2, 32'h1, d, ok);
    check("ce ack", 32'h0, {31'h0, ok});
    ce = 1'b1;
    acc(1'b0, PCR_OFS_DEVCTL2, 32'h0, d);
    check("ce hold", 32'h10, d);
    rst = 1'b1;
    repeat (2) @(negedge core_clk);
    rst = 1'b0;
    check("rdata rst2", 32'h0, cfg_rdata);
    acc(1'b0, PCR_OFS_ID, 32'h0, d);
    check("ids rst2", rows[0].e, d);
    acc(1'b0, PCR_OFS_DEVCTL2, 32'h0, d);
    check("ctl2 rst2", 32'h0, d);
    summarize();
  end
endmodule : pcie_config_id_and_capability_regs_bench
